// file: shared/ais_pkg.sv
// constants, types and carriers of the alarm indication and self-test block
// assumes one 10 MHz clock and an asynchronous active-low reset in every user
// ------------------------------------------------------------------------
// ------------------------------------------------------------------------
package ais_pkg;
    // ------------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------------
    localparam int NUM_LINES = 16; // event lines into the matrix
    localparam int NUM_LAMPS = 9; // signal lamps
    localparam int NUM_OUTS = 4; // logic outputs
    localparam int NUM_COLS = NUM_LAMPS + NUM_OUTS; // matrix columns
    localparam int HIST_DEPTH = 64; // stored messages
    localparam int MSG_W = 8; // message code width
    localparam int NUM_TESTS = 9; // major self-tests
    // ------------------------------------------------------------------------
    // event line indices
    // ------------------------------------------------------------------------
    localparam int LN_OC1 = 0; // overcurrent unit 1 trip
    localparam int LN_OC2 = 1; // overcurrent unit 2 trip
    localparam int LN_EF1 = 2; // earth fault unit 1 trip
    localparam int LN_EF2 = 3; // earth fault unit 2 trip
    localparam int LN_BRK_OPEN = 4; // breaker open input
    localparam int LN_BRK_CLOSED = 5; // breaker closed input
    localparam int LN_CTRL_TRIP = 6; // trip by breaker control
    localparam int LN_CLEARED = 7; // recloser cleared fault pulse
    localparam int LN_PERMANENT = 8; // recloser permanent fault pulse
    localparam int LN_BLOCK = 9; // blocking info transmission
    localparam int LN_TCS = 10; // trip circuit supervision
    localparam int LN_CTRL_FAULT = 11; // breaker control fault
    localparam int LN_PICKUP = 12; // pick-up
    // ------------------------------------------------------------------------
    // output columns: lamps 0..8, outputs 9..12
    // ------------------------------------------------------------------------
    localparam int COL_OUT3 = NUM_LAMPS + 2; // blocking output column
    localparam int COL_OUT4 = NUM_LAMPS + 3; // watchdog output column
    // ------------------------------------------------------------------------
    // major test indices and period masks
    // ------------------------------------------------------------------------
    localparam logic [8:0] TESTS_AT_INIT = 9'h0_1F0; // cpu, ram, conn x2, param
    localparam logic [8:0] TESTS_IN_RUN = 9'h0_0FF; // all but parameter memory
    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000; // system clock rate
    localparam int TEST_PERIOD_US = 1000; // cyclic self-test period
    localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * (CLK_HZ / 1_000_000); // cycles per test cycle
    localparam int RESTART_MS = 5000; // fail-safe hold before restart
    localparam int RESTART_CYC = RESTART_MS * (CLK_HZ / 1000); // hold in cycles
    localparam logic [2:0] TRANSIENT_LIMIT = 3'h5; // fifth transient is final
    // ------------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------------
    localparam logic [NUM_LINES-1:0] LATCH_DEFAULT = 16'h0_04F; // trips latch by default
    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'b00, // start-up tests
        ST_RUN = 2'b01, // normal operation
        ST_SAFE = 2'b10, // fail-safe, restart pending
        ST_LOCK = 2'b11 // fail-safe until power cycle
    } ais_state_t;
    typedef struct packed {
        logic clear_key; // clears displayed message
        logic ack_key; // acknowledges latched events
        logic history_key; // toggles history view
        logic delete_key; // deletes history in view
    } ais_keys_t;
    typedef struct packed {
        logic trip_circuit_fault; // trip circuit fault
        logic position_mismatch; // breaker contacts disagree
        logic order_pending; // open or close order issued
        logic order_done; // order carried out
    } ais_breaker_t;
endpackage : ais_pkg

// file: rtl/ais_history_mem.sv
// history memory for the alarm history ring
// assumes write and read addresses are in range; read data registered
`timescale 1ns/10ps
module ais_history_mem #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 8
) (
    input wire logic clk, // system clock
    input wire logic wr_en, // write strobe
    input wire logic [$clog2(DEPTH)-1:0] wr_addr, // write address
    input wire logic [WIDTH-1:0] wr_data, // write data
    input wire logic [$clog2(DEPTH)-1:0] rd_addr, // read address
    output logic [WIDTH-1:0] rd_data // registered read data
);
    logic [WIDTH-1:0] mem [DEPTH]; // storage array
    // ------------------------------------------------------------------------
    // write and registered read
    // ------------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : ais_history_mem

// file: rtl/ais_core.sv
// alarm indication, control matrix and self-test supervision
// assumes synchronous pin inputs and one-cycle key pulses from the panel
`timescale 1ns/10ps
module ais_core #(
    parameter int RESTART_CYCLES = ais_pkg::RESTART_CYC, // fail-safe hold
    parameter int TEST_CYCLES = ais_pkg::TEST_PERIOD_CYC // self-test period
) (
    input wire logic clk, // system clock
    input wire logic resetn, // asynchronous reset, active low
    input wire logic [ais_pkg::NUM_LINES-1:0] event_lines, // raw event lines
    input wire logic [ais_pkg::NUM_LINES-1:0] latch_cfg, // lines that latch
    input wire logic [ais_pkg::NUM_COLS*ais_pkg::NUM_LINES-1:0] matrix_cfg, // column selections
    input wire logic matrix_custom, // use matrix_cfg rather than defaults
    input wire logic input_module_fitted, // optional input module present
    input wire logic watchdog_used, // watchdog routed to output four
    input wire logic [3:0] instant_pickup, // instantaneous unit outputs
    input wire logic recloser_cleared, // recloser cleared fault level
    input wire logic recloser_permanent, // recloser permanent fault level
    input wire logic breaker_open_input, // breaker open contact
    input wire logic breaker_closed_input, // breaker closed contact
    input wire logic breaker_control_on, // breaker control active
    input wire logic supervision_on, // trip/closing supervision enabled
    input wire ais_pkg::ais_breaker_t breaker, // breaker status group
    input wire ais_pkg::ais_keys_t keys, // panel key pulses
    input wire logic [ais_pkg::MSG_W-1:0] event_msg, // message code of new event
    input wire logic event_valid, // new event pulse
    input wire logic [ais_pkg::NUM_TESTS-1:0] major_fail, // major test failures
    input wire logic minor_fail, // peripheral failure
    input wire logic [5:0] hist_index, // history entry to view, 0 newest
    output logic [ais_pkg::NUM_LAMPS-1:0] lamps, // signal lamps
    output logic [ais_pkg::NUM_OUTS-1:0] logic_outputs, // output relays O1..O4
    output logic protection_inhibit, // protection functions inhibited
    output logic red_failure_lamp, // red failure indicator
    output logic downgraded, // downgraded operation
    output logic message_shown, // operator panel shows a message
    output logic [ais_pkg::MSG_W-1:0] message_code, // shown message code
    output logic history_view, // history screen active
    output logic [ais_pkg::MSG_W-1:0] hist_data, // viewed history entry
    output logic [6:0] hist_count, // stored entries
    output logic supervision_status, // supervision fault status item
    output logic [2:0] transient_count, // transient failure count
    output logic test_running // self-test pass in progress
);
    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    if (RESTART_CYCLES < 1 || TEST_CYCLES < 2)
    begin : g_bad_param
        $error("ais_core: counts too small");
    end
    // ------------------------------------------------------------------------
    // derived event lines
    // ------------------------------------------------------------------------
    logic clr_d_reg; // delayed recloser cleared
    logic perm_d_reg; // delayed recloser permanent
    logic tcs_line; // trip circuit supervision line
    logic ctrl_fault_line; // breaker control fault line
    logic pickup_line; // pick-up line
    logic [ais_pkg::NUM_LINES-1:0] lines; // complete line set
    logic [ais_pkg::NUM_LINES-1:0] held_reg; // latched lines
    logic [ais_pkg::NUM_LINES-1:0] eff_lines; // lines after latching
    assign tcs_line = breaker_control_on & (breaker.trip_circuit_fault | breaker.position_mismatch);
    assign ctrl_fault_line = breaker.order_pending & ~breaker.order_done;
    assign pickup_line = |instant_pickup;
    // build the line vector, replacing derived positions
    always_comb
    begin
        lines = event_lines;
        lines[ais_pkg::LN_BRK_OPEN] = breaker_open_input & input_module_fitted;
        lines[ais_pkg::LN_BRK_CLOSED] = breaker_closed_input & input_module_fitted;
        lines[ais_pkg::LN_CLEARED] = recloser_cleared & ~clr_d_reg;
        lines[ais_pkg::LN_PERMANENT] = recloser_permanent & ~perm_d_reg;
        lines[ais_pkg::LN_TCS] = tcs_line;
        lines[ais_pkg::LN_CTRL_FAULT] = ctrl_fault_line;
        lines[ais_pkg::LN_PICKUP] = pickup_line;
    end
    assign eff_lines = lines | (held_reg & latch_cfg);
    // edge history for the pulse lines and latches
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clr_d_reg <= 1'b0;
            perm_d_reg <= 1'b0;
            held_reg <= '0;
        end
        else
        begin
            clr_d_reg <= recloser_cleared;
            perm_d_reg <= recloser_permanent;
            // new set wins over acknowledge
            held_reg <= ((keys.ack_key ? '0 : held_reg) | lines) & latch_cfg;
        end
    end
    // ------------------------------------------------------------------------
    // control matrix
    // ------------------------------------------------------------------------
    function automatic logic [ais_pkg::NUM_LINES-1:0] default_sel(input int col);
        logic [ais_pkg::NUM_LINES-1:0] s;
        s = '0;
        if (col < 4) s[col] = 1'b1;
        if (col == 6) s[ais_pkg::LN_BRK_OPEN] = 1'b1;
        if (col == 7) s[ais_pkg::LN_BRK_CLOSED] = 1'b1;
        if (col == 8) s[ais_pkg::LN_CTRL_TRIP] = 1'b1;
        if (col == ais_pkg::COL_OUT3) s[ais_pkg::LN_BLOCK] = 1'b1;
        return s;
    endfunction : default_sel
    logic [ais_pkg::NUM_COLS-1:0] col_or; // column results
    for (genvar c = 0; c < ais_pkg::NUM_COLS; c++)
    begin : g_col
        wire [ais_pkg::NUM_LINES-1:0] sel = matrix_custom ?
            matrix_cfg[c*ais_pkg::NUM_LINES +: ais_pkg::NUM_LINES] : default_sel(c);
        assign col_or[c] = |(sel & eff_lines);
    end
    // ------------------------------------------------------------------------
    // self-test sequencer and failure classes
    // ------------------------------------------------------------------------
    ais_pkg::ais_state_t state_reg, state_next; // supervision state
    logic [31:0] timer_reg; // period / hold timer
    logic [2:0] trans_reg; // transient failure counter
    logic major_now; // major failure in current test set
    logic restart_done; // hold time elapsed
    logic [ais_pkg::NUM_TESTS-1:0] active_tests; // tests of current period
    assign active_tests = (state_reg == ais_pkg::ST_INIT || state_reg == ais_pkg::ST_SAFE) ?
        ais_pkg::TESTS_AT_INIT : ais_pkg::TESTS_IN_RUN;
    assign major_now = |(major_fail & active_tests);
    assign restart_done = (timer_reg == 32'(RESTART_CYCLES - 1));
    // next state
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ais_pkg::ST_INIT:
            begin
                // one init pass, then run
                state_next = major_now ? ais_pkg::ST_SAFE : ais_pkg::ST_RUN;
            end
            ais_pkg::ST_RUN:
            begin
                if (major_now) state_next = ais_pkg::ST_SAFE;
            end
            ais_pkg::ST_SAFE:
            begin
                if (restart_done)
                begin
                    if (major_now) state_next = ais_pkg::ST_LOCK; // permanent failure
                    else if (trans_reg + 3'h1 >= ais_pkg::TRANSIENT_LIMIT) state_next = ais_pkg::ST_LOCK;
                    else state_next = ais_pkg::ST_INIT;
                end
            end
            ais_pkg::ST_LOCK:
            begin
                state_next = ais_pkg::ST_LOCK;
            end
        endcase
    end
    // state, timer and transient counter
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg <= ais_pkg::ST_INIT;
            timer_reg <= '0;
            trans_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg) timer_reg <= '0;
            else if (state_reg == ais_pkg::ST_RUN && timer_reg == 32'(TEST_CYCLES - 1)) timer_reg <= '0;
            else timer_reg <= timer_reg + 32'h0000_0001;
            if (state_reg == ais_pkg::ST_SAFE && restart_done && !major_now) trans_reg <= trans_reg + 3'h1;
        end
    end
    // ------------------------------------------------------------------------
    // message display and history
    // ------------------------------------------------------------------------
    logic [5:0] wr_ptr_reg; // next history slot
    logic [6:0] count_reg; // stored entries
    logic hist_clear; // delete while in view
    logic [5:0] rd_addr; // viewed slot
    logic [ais_pkg::MSG_W-1:0] mem_rd; // memory read data
    assign hist_clear = keys.delete_key & history_view;
    assign rd_addr = 6'(wr_ptr_reg - 6'h01 - hist_index);
    ais_history_mem #(
        .DEPTH(ais_pkg::HIST_DEPTH),
        .WIDTH(ais_pkg::MSG_W)
    ) u_mem (
        .clk(clk),
        .wr_en(event_valid),
        .wr_addr(wr_ptr_reg),
        .wr_data(event_msg),
        .rd_addr(rd_addr),
        .rd_data(mem_rd)
    );
    // history pointers, display and view
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_reg <= '0;
            count_reg <= '0;
            message_shown <= 1'b0;
            message_code <= '0;
            history_view <= 1'b0;
        end
        else
        begin
            if (hist_clear)
            begin
                wr_ptr_reg <= event_valid ? 6'h01 : 6'h00;
                count_reg <= event_valid ? 7'h01 : 7'h00;
            end
            else if (event_valid)
            begin
                wr_ptr_reg <= wr_ptr_reg + 6'h01;
                if (count_reg != 7'(ais_pkg::HIST_DEPTH)) count_reg <= count_reg + 7'h01;
            end
            if (event_valid)
            begin
                message_shown <= 1'b1;
                message_code <= event_msg;
            end
            else if (keys.clear_key)
            begin
                message_shown <= 1'b0;
            end
            if (keys.history_key) history_view <= ~history_view;
        end
    end
    // ------------------------------------------------------------------------
    // registered outputs and fail-safe forcing
    // ------------------------------------------------------------------------
    logic safe; // fail-safe position
    assign safe = (state_reg == ais_pkg::ST_SAFE) || (state_reg == ais_pkg::ST_LOCK);
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lamps <= '0;
            logic_outputs <= '0;
            protection_inhibit <= 1'b1;
            red_failure_lamp <= 1'b0;
            downgraded <= 1'b0;
            hist_data <= '0;
            hist_count <= '0;
            supervision_status <= 1'b0;
            transient_count <= '0;
            test_running <= 1'b0;
        end
        else
        begin
            lamps <= col_or[ais_pkg::NUM_LAMPS-1:0];
            logic_outputs <= safe ? '0 : col_or[ais_pkg::NUM_COLS-1:ais_pkg::NUM_LAMPS];
            if (watchdog_used) logic_outputs[3] <= ~safe && state_reg == ais_pkg::ST_RUN;
            protection_inhibit <= safe || state_reg == ais_pkg::ST_INIT;
            red_failure_lamp <= safe;
            downgraded <= minor_fail & ~safe;
            hist_data <= mem_rd;
            hist_count <= count_reg;
            supervision_status <= supervision_on & (tcs_line | ctrl_fault_line);
            transient_count <= trans_reg;
            test_running <= state_reg == ais_pkg::ST_INIT || timer_reg == '0;
        end
    end
endmodule : ais_core

// file: sim/ais_panel_model.sv
// operator panel model: turns key requests into one-cycle key pulses
// assumes the bench calls press() at a falling edge of clk
`timescale 1ns/10ps
module ais_panel_model (
    input wire logic clk, // system clock
    output ais_pkg::ais_keys_t keys // key pulses to the core
);
    // keys idle until the operator presses one
    initial keys = '0;
    // one press: key high for one full cycle, changed at falling edges
    task automatic press(input logic [3:0] k);
        @(negedge clk);
        keys = k;
        @(negedge clk);
        keys = '0;
    endtask : press
endmodule : ais_panel_model

// file: sim/ais_core_checker.sv
// concurrent checks on the ports of the alarm indication core
// assumes one clock and the core's asynchronous active-low reset
`timescale 1ns/10ps
module ais_core_checker (
    input wire logic clk, // clock
    input wire logic resetn, // reset, active low
    input wire ais_pkg::ais_keys_t keys, // key pulses
    input wire logic event_valid, // new event
    input wire logic [7:0] event_msg, // event code
    input wire logic [15:0] latch_cfg, // latching lines
    input wire logic matrix_custom, // custom matrix
    input wire logic supervision_on, // supervision enabled
    input wire logic breaker_control_on, // control active
    input wire ais_pkg::ais_breaker_t breaker, // breaker group
    input wire logic [8:0] major_fail, // major failures
    input wire logic [8:0] lamps, // lamps
    input wire logic [3:0] logic_outputs, // relays
    input wire logic protection_inhibit, // inhibit
    input wire logic red_failure_lamp, // red lamp
    input wire logic message_shown, // message on panel
    input wire logic [7:0] message_code, // shown code
    input wire logic history_view, // history screen
    input wire logic [6:0] hist_count, // stored entries
    input wire logic supervision_status // supervision item
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    msg_show_a: assert property (event_valid |=> message_shown && message_code == $past(event_msg))
        else $error("event message not shown");
    msg_clear_a: assert property (keys.clear_key && !event_valid |=> !message_shown)
        else $error("message stays after clear key");
    hist_bound_a: assert property (hist_count <= 7'h40)
        else $error("history count above depth");
    delete_guard_a: assert property (keys.delete_key && !history_view && !event_valid
        |=> ##1 $stable(hist_count))
        else $error("history erased outside view");
    safe_idle_a: assert property (red_failure_lamp |-> logic_outputs == 4'h0 && protection_inhibit)
        else $error("outputs live in fail-safe");
    major_entry_a: assert property ((major_fail & ais_pkg::TESTS_IN_RUN) != 0 && logic_outputs[3]
        |-> ##[1:3] red_failure_lamp)
        else $error("major failure without fail-safe");
    latch_hold_a: assert property (lamps[0] && latch_cfg[0] && $stable(latch_cfg) && !matrix_custom
        && !keys.ack_key && !$past(keys.ack_key) |=> lamps[0])
        else $error("latched lamp dropped without ack");
    sup_item_a: assert property (supervision_on && breaker_control_on && !red_failure_lamp
        && breaker.position_mismatch |-> ##[1:2] supervision_status)
        else $error("supervision item not set");
endmodule : ais_core_checker
bind ais_core ais_core_checker chk (.clk(clk), .resetn(resetn), .keys(keys), .event_valid(event_valid),
    .event_msg(event_msg), .latch_cfg(latch_cfg), .matrix_custom(matrix_custom), .supervision_on(supervision_on),
    .breaker_control_on(breaker_control_on), .breaker(breaker), .major_fail(major_fail), .lamps(lamps),
    .logic_outputs(logic_outputs), .protection_inhibit(protection_inhibit), .red_failure_lamp(red_failure_lamp),
    .message_shown(message_shown), .message_code(message_code), .history_view(history_view),
    .hist_count(hist_count), .supervision_status(supervision_status));

// file: sim/ais_core_tb.sv
// self-checking bench for the alarm indication core
// assumes the shared package, panel model and checker compiled first
`timescale 1ns/10ps
module ais_core_tb;
    // ------------------------------------------------------------------------
    // stimulus and observed outputs
    // ------------------------------------------------------------------------
    localparam int RST_CYC = 20; // short fail-safe hold
    logic clk = 0, resetn = 0, matrix_custom = 0, fitted = 0, wd_used = 0, rc_clr = 0, rc_perm = 0;
    logic bro = 0, brc = 0, bc_on = 0, sup_on = 0, ev_valid = 0, minor = 0;
    logic [15:0] lines = 0, latch = 0;
    logic [207:0] mcfg = 0; // column 0 in bits 15:0
    logic [3:0] pick = 0;
    logic [7:0] ev_msg = 0, code, hdata;
    logic [8:0] major = 0, lamps;
    logic [5:0] hidx = 0;
    ais_pkg::ais_breaker_t brk = '0;
    ais_pkg::ais_keys_t keys;
    logic [3:0] louts;
    logic inhibit, red, degr, shown, hview, sup_st, trun;
    logic [6:0] hcnt;
    logic [2:0] tcnt;
    int err_count = 0, cmp_count = 0, n, k;
    // row: custom, col0, lines, pickup, bro brc fit wd, lamps, O4 O3
    logic [51:0] rows [11] = '{{1'b0, 16'h0, 16'h1, 4'h0, 4'h0, 9'h001, 2'h0}, {1'b0, 16'h0, 16'hF, 4'h0, 4'h0, 9'h00F, 2'h0},
        {1'b0, 16'h0, 16'h40, 4'h0, 4'h0, 9'h100, 2'h0}, {1'b0, 16'h0, 16'h0, 4'h0, 4'hA, 9'h040, 2'h0},
        {1'b0, 16'h0, 16'h0, 4'h0, 4'h8, 9'h000, 2'h0}, {1'b0, 16'h0, 16'h0, 4'h0, 4'h6, 9'h080, 2'h0},
        {1'b0, 16'h0, 16'h200, 4'h0, 4'h0, 9'h000, 2'h1}, {1'b0, 16'h0, 16'h0, 4'h0, 4'h1, 9'h000, 2'h2},
        {1'b1, 16'h1000, 16'h0, 4'h4, 4'h0, 9'h001, 2'h0}, {1'b1, 16'h3, 16'h2, 4'h0, 4'h0, 9'h001, 2'h0},
        {1'b1, 16'h3, 16'h0, 4'h0, 4'h0, 9'h000, 2'h0}};
    always #50 clk = ~clk;
    ais_panel_model panel (.clk(clk), .keys(keys));
    ais_core #(.RESTART_CYCLES(RST_CYC), .TEST_CYCLES(8)) dut (.clk(clk), .resetn(resetn), .event_lines(lines),
        .latch_cfg(latch), .matrix_cfg(mcfg), .matrix_custom(matrix_custom), .input_module_fitted(fitted),
        .watchdog_used(wd_used), .instant_pickup(pick), .recloser_cleared(rc_clr), .recloser_permanent(rc_perm),
        .breaker_open_input(bro), .breaker_closed_input(brc), .breaker_control_on(bc_on), .supervision_on(sup_on),
        .breaker(brk), .keys(keys), .event_msg(ev_msg), .event_valid(ev_valid), .major_fail(major),
        .minor_fail(minor), .hist_index(hidx), .lamps(lamps), .logic_outputs(louts), .protection_inhibit(inhibit),
        .red_failure_lamp(red), .downgraded(degr), .message_shown(shown), .message_code(code),
        .history_view(hview), .hist_data(hdata), .hist_count(hcnt), .supervision_status(sup_st),
        .transient_count(tcnt), .test_running(trun));
    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic tick(input int c);
        repeat (c) @(negedge clk);
    endtask : tick
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        tick(5);
        check("reset outputs", {louts, lamps, inhibit, shown}, 15'h0002);
        tick(5);
        resetn = 1;
        tick(2);
        $display("test reset done");
        // table of matrix and lamp assignments
        foreach (rows[i])
        begin
            {matrix_custom, mcfg[15:0], lines, pick, bro, brc, fitted, wd_used} = rows[i][51:11];
            tick(3);
            check("lamps", lamps, rows[i][10:2]);
            check("outputs", louts[3:2], rows[i][1:0]);
        end
        $display("test matrix done");
        // 65 back-to-back events: oldest overwritten
        {matrix_custom, lines, pick, fitted, wd_used} = '0;
        ev_valid = 1;
        for (n = 1; n <= 65; n++)
        begin
            ev_msg = n[7:0];
            tick(1);
        end
        ev_valid = 0;
        tick(3);
        check("shown", {shown, code}, 9'h141);
        check("count", hcnt, 7'h40);
        check("newest", hdata, 8'h41);
        hidx = 6'h3F;
        tick(3);
        check("oldest", hdata, 8'h02);
        panel.press(4'h8);
        tick(1);
        check("cleared", shown, 1'b0);
        panel.press(4'h1);
        tick(1);
        check("kept", hcnt, 7'h40);
        panel.press(4'h2);
        panel.press(4'h1);
        tick(1);
        check("erased", {hview, hcnt}, 8'h80);
        panel.press(4'h2);
        $display("test history done");
        // latched lamp released only by acknowledge
        latch = ais_pkg::LATCH_DEFAULT;
        lines = 16'h1;
        tick(1);
        lines = 0;
        tick(3);
        check("latched", lamps[0], 1'b1);
        panel.press(4'h4);
        tick(2);
        check("acked", lamps[0], 1'b0);
        // recloser levels reach the matrix as single pulses
        matrix_custom = 1;
        for (n = 0; n < 2; n++)
        begin
            mcfg[15:0] = n ? 16'h100 : 16'h80;
            rc_clr = (n == 0);
            rc_perm = (n == 1);
            k = 0;
            repeat (8)
            begin
                tick(1);
                k += lamps[0];
            end
            check("pulse", k[15:0], 16'h1);
            {rc_clr, rc_perm} = 2'h0;
            tick(2);
        end
        // supervision line and status item
        mcfg[15:0] = 16'h400;
        bc_on = 1;
        sup_on = 1;
        brk.position_mismatch = 1;
        tick(3);
        check("tcs line", lamps[0], 1'b1);
        check("tcs status", sup_st, 1'b1);
        brk = '0;
        minor = 1;
        tick(3);
        check("downgraded", {degr, inhibit}, 2'h2);
        minor = 0;
        k = 0;
        repeat (20)
        begin
            tick(1);
            k += trun;
        end
        check("test passes", k >= 2, 1'b1);
        $display("test indications done");
        // five transient major failures: the fifth locks fail-safe
        {matrix_custom, wd_used, lines} = {1'b0, 1'b1, 16'h200};
        for (n = 1; n <= 5; n++)
        begin
            tick(2);
            check("watchdog", louts[3], 1'b1);
            major = 9'h002;
            k = 0;
            while (red !== 1'b1 && k < 10)
            begin
                tick(1);
                k++;
            end
            check("safe wait", k < 10, 1'b1);
            if (k >= 10)
                end_sim;
            tick(1);
            check("safe state", {louts, inhibit}, 5'h01);
            major = 0;
            tick(RST_CYC + 20);
            check("transients", tcnt, n[2:0]);
            check("locked", red, n == 5);
        end
        $display("test fail-safe done");
        end_sim;
    end
endmodule : ais_core_tb
